// ==== include/dcs_params.svh ====
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH

// command field codes
`define DCS_FN_MAINT     3'h0
`define DCS_FN_SEEK      3'h3

// status word bit positions
`define DCS_B_IE         6
`define DCS_B_CONTROLLER_READY       7
`define DCS_B_OPI        10
`define DCS_B_CRC        11
`define DCS_B_DLT        12
`define DCS_B_NXM        13
`define DCS_B_DRV        14

// self-test figures
`define DCS_ST_WC        16'h9fc1
`define DCS_ST_RD_WORDS  9'h100
`define DCS_ST_WR_WORDS  9'h0ff
`define DCS_ST_WR_OFS    22'h000200
`define DCS_ST_ADDR_STEP 22'h000002
`define DCS_ST_LOGIC_N   2'h2
`define DCS_CRC_POLY     16'h8005
`define DCS_WC_LAST      16'hffff

// reset values
`define DCS_RST_WORD     16'h0000
`define DCS_RST_ADDR     22'h000000

`endif

// ==== include/dcs_pkg.sv ====
package dcs_pkg;

   typedef enum logic [3:0] {
      DCS_IDLE   = 4'b0000,
      DCS_XFER   = 4'b0001,
      DCS_LOGIC  = 4'b0010,
      DCS_DMA    = 4'b0011,
      DCS_LAST   = 4'b0100,
      DCS_CRC_A  = 4'b0101,
      DCS_CRC_B  = 4'b0110,
      DCS_CRC_C  = 4'b0111
   } dcs_state_t;

   // error events from the transfer datapath, one-cycle pulses
   typedef struct packed {
      logic data_crc;
      logic hdr_crc;
      logic cmp_fail;
      logic data_late;
      logic hdr_nf;
      logic nonexistent_mem_err;
      logic parity;
      logic abort;
      logic op_incomplete;
   } dcs_err_evt_t;

   // controller error bits 10..13
   typedef struct packed {
      logic nonexistent_mem_err;
      logic data_late_err;
      logic crc;
      logic op_incomplete_err;
   } dcs_err_t;

   // one dma request held until acknowledged
   typedef struct packed {
      logic        we;
      logic [21:0] addr;
      logic [15:0] wdata;
   } dcs_dma_req_t;

endpackage

// ==== logic/dcs_fifo.sv ====
`timescale 1ns/1ps
module dcs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign o_in_ready  = (cnt_r != DEPTH[AW:0]);
   assign o_out_valid = (cnt_r != '0);
   assign push        = i_in_valid & o_in_ready;
   assign pop         = i_out_ready & o_out_valid;
   assign o_out_data  = mem[rd_ptr_r];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

// ==== logic/dcs_ctrl.sv ====
// How it works
// - function code 0 starts the self-test
// - wrong word count gives header-not-found
// - self-test never touches the drive pins
// - six tests, disk address bumped after each
// - logic, logic, dma, crc, crc, crc-of-crc
// - read 256 words from base into fifo
// - write 255 words back from base+1000
// - two crc words left for reading
// - low address byte ends at start plus 6
// - low byte carry never reaches high byte
// - seek hand-off: ready and interrupt at once
// - no interrupt when positioning completes
// - new seek accepted while drives still move
// - incomplete operation sets bit 10 only
// - any crc or compare error sets bit 11
// - late sets 12; not-found sets 10 and 12
// - nonexistent memory or parity sets 13
// - aborted command sets 10 and 13
// - drive error shows on bit 14
// - new command clears bits 10 to 13
// - ready set at completion and on error
// - word count counts up, overflow ends transfer
`timescale 1ns/1ps
`include "dcs_params.svh"
module dcs_ctrl import dcs_pkg::*; #(
   parameter int FIFO_DEPTH = 32
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_go,
   input  wire logic [2:0]   i_func,
   input  wire logic         i_ie,
   input  wire logic         i_dar_wr,
   input  wire logic [15:0]  i_dar_wdata,
   input  wire logic         i_wc_wr,
   input  wire logic [15:0]  i_wc_wdata,
   input  wire logic         i_bar_wr,
   input  wire logic [15:0]  i_bar_wdata,
   input  wire logic         i_bae_wr,
   input  wire logic [5:0]   i_bae_wdata,
   input  wire logic         i_mpr_rd,
   input  wire logic         i_word_moved,
   input  wire logic         i_cmd_done,
   input  wire dcs_err_evt_t i_err_evt,
   input  wire logic         i_dma_ack,
   input  wire logic         i_dma_err,
   input  wire logic [15:0]  i_dma_rdata,
   input  wire logic         i_drive_ready,
   input  wire logic         i_drive_err,
   output logic              o_ready,
   output logic              o_irq,
   output logic [15:0]       o_status,
   output logic [15:0]       o_disk_address_reg,
   output logic [15:0]       o_word_count,
   output logic              o_mpr_valid,
   output logic [15:0]       o_multipurpose_reg,
   output logic              o_dma_req,
   output dcs_dma_req_t      o_dma,
   output logic              o_pos_valid,
   output logic [15:0]       o_pos_word
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   dcs_state_t   state_r;
   dcs_state_t   state_nxt;
   logic         ready_r;
   logic         irq_r;
   dcs_err_t     err_r;
   dcs_err_t     err_set;
   logic [15:0]  dar_r;
   logic [15:0]  wc_r;
   logic [15:0]  bar_r;
   logic [5:0]   bae_r;
   logic [1:0]   logic_n_r;
   logic [8:0]   rd_cnt_r;
   logic [8:0]   wr_cnt_r;
   logic [15:0]  crc_b_r;
   logic         req_r;
   dcs_dma_req_t dma_r;
   logic         pos_valid_r;
   logic [15:0]  pos_word_r;
   logic         drive_ready_s1_r;
   logic         drive_ready_s2_r;
   logic         derr_s1_r;
   logic         derr_s2_r;
   logic         cmd_go;
   logic         done_evt;
   logic         dar_inc;
   logic         wc_inc;
   logic         st_err;
   logic         issue_rd;
   logic         issue_wr;
   logic         fifo_in_valid;
   logic         fifo_in_ready;
   logic [15:0]  fifo_in_data;
   logic         fifo_out_valid;
   logic         fifo_out_ready;
   logic [15:0]  fifo_out_data;
   logic [21:0]  base_addr;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [15:0] crc16(input logic [15:0] d);
      logic [15:0] c;
      logic        fb;
      c = 16'h0000;
      for (int i = 15; i >= 0; i--) begin
         fb = c[15] ^ d[i];
         c = {c[14:0], 1'b0};
         if (fb) begin
            c = c ^ `DCS_CRC_POLY;
         end
      end
      return c;
   endfunction

   // pins from the drive cross in from outside the clock
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         drive_ready_s1_r <= 1'b0;
         drive_ready_s2_r <= 1'b0;
         derr_s1_r <= 1'b0;
         derr_s2_r <= 1'b0;
      end else begin
         drive_ready_s1_r <= i_drive_ready;
         drive_ready_s2_r <= drive_ready_s1_r;
         derr_s1_r <= i_drive_err;
         derr_s2_r <= derr_s1_r;
      end
   end

   // commands only taken while ready, as the host must wait for it
   assign cmd_go    = i_go & ready_r;
   assign base_addr = {bae_r, bar_r};

   ////////////////////////////////////////////////////////////////////////
   // sequencer

   assign st_err = (state_r == DCS_LOGIC) && (wc_r != `DCS_ST_WC);

   assign issue_rd = (state_r == DCS_DMA) && !req_r
                     && (rd_cnt_r != `DCS_ST_RD_WORDS) && fifo_in_ready;
   assign issue_wr = (state_r == DCS_DMA) && !req_r && !issue_rd
                     && (wr_cnt_r != `DCS_ST_WR_WORDS) && fifo_out_valid;

   always_comb begin
      state_nxt = state_r;
      dar_inc   = 1'b0;
      done_evt  = 1'b0;
      case (state_r)
         DCS_IDLE: begin
            if (cmd_go) begin
               if (i_func == `DCS_FN_MAINT) begin
                  state_nxt = DCS_LOGIC;
               end else if (i_func == `DCS_FN_SEEK) begin
                  done_evt = 1'b1;
               end else begin
                  state_nxt = DCS_XFER;
               end
            end
         end
         DCS_XFER: begin
            if ((wc_inc && wc_r == `DCS_WC_LAST) || i_cmd_done
                || (|i_err_evt)) begin
               done_evt  = 1'b1;
               state_nxt = DCS_IDLE;
            end
         end
         DCS_LOGIC: begin
            if (st_err) begin
               done_evt  = 1'b1;
               state_nxt = DCS_IDLE;
            end else begin
               dar_inc = 1'b1;
               if (logic_n_r == `DCS_ST_LOGIC_N - 2'h1) begin
                  state_nxt = DCS_DMA;
               end
            end
         end
         DCS_DMA: begin
            if (req_r && i_dma_ack && i_dma_err) begin
               done_evt  = 1'b1;
               state_nxt = DCS_IDLE;
            end else if (rd_cnt_r == `DCS_ST_RD_WORDS
                         && wr_cnt_r == `DCS_ST_WR_WORDS && !req_r) begin
               state_nxt = DCS_LAST;
            end
         end
         DCS_LAST: begin
            // drop the one word never written back
            dar_inc   = 1'b1;
            state_nxt = DCS_CRC_A;
         end
         DCS_CRC_A: begin
            dar_inc   = 1'b1;
            state_nxt = DCS_CRC_B;
         end
         DCS_CRC_B: begin
            dar_inc   = 1'b1;
            state_nxt = DCS_CRC_C;
         end
         DCS_CRC_C: begin
            dar_inc   = 1'b1;
            done_evt  = 1'b1;
            state_nxt = DCS_IDLE;
         end
         default: begin
            state_nxt = DCS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r   <= DCS_IDLE;
         logic_n_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         if (state_r == DCS_LOGIC) begin
            logic_n_r <= logic_n_r + 2'h1;
         end else begin
            logic_n_r <= 2'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ready and interrupt

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ready_r <= 1'b1;
         irq_r   <= 1'b0;
      end else begin
         if (done_evt) begin
            ready_r <= 1'b1;
         end else if (cmd_go) begin
            ready_r <= 1'b0;
         end
         irq_r <= done_evt & i_ie;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // error bits

   always_comb begin
      err_set = '0;
      err_set.op_incomplete_err = i_err_evt.op_incomplete;
      err_set.crc = i_err_evt.data_crc | i_err_evt.hdr_crc
                    | i_err_evt.cmp_fail;
      err_set.data_late_err = i_err_evt.data_late | i_err_evt.hdr_nf | st_err;
      err_set.op_incomplete_err = err_set.op_incomplete_err | i_err_evt.hdr_nf | st_err;
      err_set.nonexistent_mem_err = i_err_evt.nonexistent_mem_err | i_err_evt.parity
                    | (req_r & i_dma_ack & i_dma_err);
      err_set.nonexistent_mem_err = err_set.nonexistent_mem_err | i_err_evt.abort;
      err_set.op_incomplete_err = err_set.op_incomplete_err | i_err_evt.abort;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         err_r <= '0;
      end else if (cmd_go) begin
         err_r <= err_set;
      end else begin
         err_r <= err_r | err_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // host-loaded registers

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dar_r <= `DCS_RST_WORD;
      end else if (i_dar_wr && ready_r) begin
         dar_r <= i_dar_wdata;
      end else if (dar_inc) begin
         dar_r <= {dar_r[15:8], dar_r[7:0] + 8'h01};
      end
   end

   assign wc_inc = (state_r == DCS_XFER && i_word_moved)
                   || (state_r == DCS_DMA && req_r && i_dma_ack);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wc_r <= `DCS_RST_WORD;
      end else if (i_wc_wr && ready_r) begin
         wc_r <= i_wc_wdata;
      end else if (wc_inc) begin
         wc_r <= wc_r + 16'h0001;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bar_r <= `DCS_RST_WORD;
         bae_r <= 6'h00;
      end else begin
         if (i_bar_wr && ready_r) begin
            bar_r <= i_bar_wdata;
         end
         if (i_bae_wr && ready_r) begin
            bae_r <= i_bae_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // dma loopback

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         req_r    <= 1'b0;
         dma_r    <= '0;
         rd_cnt_r <= 9'h000;
         wr_cnt_r <= 9'h000;
      end else if (state_r == DCS_LOGIC) begin
         req_r    <= 1'b0;
         rd_cnt_r <= 9'h000;
         wr_cnt_r <= 9'h000;
      end else if (issue_rd) begin
         req_r      <= 1'b1;
         dma_r.we   <= 1'b0;
         dma_r.addr <= base_addr + 22'(rd_cnt_r) * `DCS_ST_ADDR_STEP;
         rd_cnt_r   <= rd_cnt_r + 9'h001;
      end else if (issue_wr) begin
         req_r       <= 1'b1;
         dma_r.we    <= 1'b1;
         dma_r.wdata <= fifo_out_data;
         dma_r.addr  <= base_addr + `DCS_ST_WR_OFS
                        + 22'(wr_cnt_r) * `DCS_ST_ADDR_STEP;
         wr_cnt_r    <= wr_cnt_r + 9'h001;
      end else if (i_dma_ack) begin
         req_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // crc path and fifo

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         crc_b_r <= `DCS_RST_WORD;
      end else if (state_r == DCS_CRC_B) begin
         crc_b_r <= crc16(dar_r);
      end
   end

   always_comb begin
      fifo_in_valid = 1'b0;
      fifo_in_data  = i_dma_rdata;
      if (state_r == DCS_DMA && req_r && i_dma_ack && !dma_r.we) begin
         fifo_in_valid = !i_dma_err;
      end else if (state_r == DCS_CRC_A) begin
         fifo_in_valid = 1'b1;
         fifo_in_data  = crc16(dar_r);
      end else if (state_r == DCS_CRC_C) begin
         fifo_in_valid = 1'b1;
         fifo_in_data  = crc16(crc_b_r);
      end
   end

   // starting a self-test throws away one stale word
   assign fifo_out_ready = issue_wr
                           || (state_r == DCS_LAST)
                           || (cmd_go && i_func == `DCS_FN_MAINT)
                           || (i_mpr_rd && ready_r);

   dcs_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (fifo_in_valid),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (fifo_in_data),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_out_ready),
      .o_out_data  (fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // drive hand-off

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pos_valid_r <= 1'b0;
         pos_word_r  <= `DCS_RST_WORD;
      end else begin
         pos_valid_r <= cmd_go && i_func == `DCS_FN_SEEK;
         if (cmd_go && i_func == `DCS_FN_SEEK) begin
            pos_word_r <= dar_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   always_comb begin
      o_status                = 16'h0000;
      o_status[3:1]           = i_func;
      o_status[`DCS_B_IE]     = i_ie;
      o_status[`DCS_B_CONTROLLER_READY]   = ready_r;
      o_status[`DCS_B_OPI]    = err_r.op_incomplete_err;
      o_status[`DCS_B_CRC]    = err_r.crc;
      o_status[`DCS_B_DLT]    = err_r.data_late_err;
      o_status[`DCS_B_NXM]    = err_r.nonexistent_mem_err;
      o_status[`DCS_B_DRV]    = derr_s2_r;
      o_status[0]             = drive_ready_s2_r;
      o_status[15]            = |{err_r, derr_s2_r};
   end

   assign o_ready            = ready_r;
   assign o_irq              = irq_r;
   assign o_disk_address_reg = dar_r;
   assign o_word_count       = wc_r;
   assign o_mpr_valid        = fifo_out_valid & ready_r;
   assign o_multipurpose_reg = fifo_out_data;
   assign o_dma_req          = req_r;
   assign o_dma              = dma_r;
   assign o_pos_valid        = pos_valid_r;
   assign o_pos_word         = pos_word_r;

endmodule

// ==== tb/dcs_ctrl_checker.sv ====
`timescale 1ns/1ps
module dcs_ctrl_checker import dcs_pkg::*; #(
   parameter int FIFO_DEPTH = 32
) (
   input wire logic          i_clk,
   input wire logic          i_rst_n,
   input wire logic          i_go,
   input wire logic [2:0]    i_func,
   input wire logic          i_ie,
   input wire logic          i_word_moved,
   input wire logic          i_dma_ack,
   input wire logic          o_ready,
   input wire logic          o_irq,
   input wire logic [15:0]   o_status,
   input wire logic [15:0]   o_disk_address_reg,
   input wire logic [15:0]   o_word_count,
   input wire logic          o_dma_req,
   input wire dcs_dma_req_t  o_dma,
   input wire logic          o_pos_valid
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence seek_go_s;
      i_go && o_ready && i_func == 3'h3;
   endsequence
   sequence st_go_s;
      i_go && o_ready && i_func == 3'h0;
   endsequence
   //////////////////////////////////////////////////////////////////////////
   seek_pos_a: assert property (
      seek_go_s |=> o_pos_valid && o_ready) else $error("seek not handed");
   seek_irq_a: assert property (
      seek_go_s ##0 i_ie |=> o_irq) else $error("seek irq missing");
   st_clear_a: assert property (
      st_go_s ##0 (o_word_count == 16'h9fc1)
      |-> ##[1:2] (!o_ready && o_status[13:10] == 4'h0))
      else $error("self-test start wrong");
   st_hnf_a: assert property (
      st_go_s ##0 (o_word_count != 16'h9fc1)
      |-> ##[1:3] (o_status[13:10] == 4'h5)) else $error("bad count kept");
   done_irq_a: assert property (
      $rose(o_ready) && $past(i_ie) |-> o_irq)
      else $error("done irq missing");
   irq_cause_a: assert property (
      o_irq |-> ($past(i_go) && $past(i_func) == 3'h3)
      || (o_ready && !$past(o_ready))) else $error("stray irq");
   dma_hold_a: assert property (
      o_dma_req && !i_dma_ack |=> o_dma_req && $stable(o_dma))
      else $error("dma request moved");
   hi_byte_a: assert property (
      !o_ready && !$past(o_ready) |-> $stable(o_disk_address_reg[15:8]))
      else $error("address high byte moved");
   wc_end_a: assert property (
      !o_ready && i_word_moved && o_word_count == 16'hffff
      |-> ##[1:3] o_ready) else $error("overflow did not end");
endmodule
bind dcs_ctrl dcs_ctrl_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_dcs_ctrl_checker (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(i_go), .i_func(i_func),
   .i_ie(i_ie), .i_word_moved(i_word_moved), .i_dma_ack(i_dma_ack),
   .o_ready(o_ready), .o_irq(o_irq), .o_status(o_status),
   .o_disk_address_reg(o_disk_address_reg), .o_word_count(o_word_count),
   .o_dma_req(o_dma_req), .o_dma(o_dma), .o_pos_valid(o_pos_valid)
);

// ==== tb/dcs_mem_model.sv ====
`timescale 1ns/1ps
module dcs_mem_model import dcs_pkg::*; (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_req,
   input  wire dcs_dma_req_t i_dma,
   input  wire logic         i_err_en,
   output logic              o_ack,
   output logic              o_err,
   output logic [15:0]       o_rdata,
   output logic [15:0]       o_rd_cnt,
   output logic [15:0]       o_wr_cnt
);
   logic [15:0] mem [0:2047];
   logic [1:0]  wait_r;
   logic        slow_r;
   initial begin
      for (int i = 0; i < 2048; i++) mem[i] = 16'h5a00 ^ 16'(i);
   end
   //////////////////////////////////////////////////////////////////////////
   // serve reads and writes
   // answers alternate prompt and slow; idle data toggles, never holds
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {o_ack, o_err, slow_r, wait_r} <= '0;
         {o_rdata, o_rd_cnt, o_wr_cnt} <= '0;
      end else begin
         o_ack <= 1'b0;
         o_err <= 1'b0;
         o_rdata <= ~o_rdata;
         if (i_req && !o_ack && wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
         end else if (i_req && !o_ack) begin
            o_ack <= 1'b1;
            o_err <= i_err_en;
            o_rdata <= mem[i_dma.addr[11:1]];
            slow_r <= ~slow_r;
            wait_r <= slow_r ? 2'h2 : 2'h0;
            if (i_dma.we) begin
               mem[i_dma.addr[11:1]] <= i_dma.wdata;
               o_wr_cnt <= o_wr_cnt + 16'h1;
            end else begin
               o_rd_cnt <= o_rd_cnt + 16'h1;
            end
         end
      end
   end
endmodule

// ==== tb/dcs_ctrl_tb_top.sv ====
`timescale 1ns/1ps
module dcs_ctrl_tb_top import dcs_pkg::*;;
   logic         i_clk = 1'b0;
   logic         i_rst_n, i_go, i_ie, i_mpr_rd, i_word_moved, i_cmd_done;
   logic         i_dar_wr, i_wc_wr, i_bar_wr, i_bae_wr, mem_err;
   logic         i_drive_ready, i_drive_err, i_dma_ack, i_dma_err;
   logic [2:0]   i_func;
   logic [5:0]   i_bae_wdata;
   logic [15:0]  i_dar_wdata, i_wc_wdata, i_bar_wdata, i_dma_rdata;
   logic [15:0]  o_status, o_disk_address_reg, o_word_count, o_pos_word;
   logic [15:0]  o_multipurpose_reg, rd_cnt, wr_cnt;
   logic         o_ready, o_irq, o_mpr_valid, o_dma_req, o_pos_valid;
   dcs_err_evt_t i_err_evt;
   dcs_dma_req_t o_dma;
   logic [15:0]  irq_cnt = '0, pos_cnt = '0;
   logic [3:0]   exp_tbl [9] = '{4'h2, 4'h2, 4'h2, 4'h4, 4'h5, 4'h8, 4'h8,
                                 4'h9, 4'h1};
   int           err_total = 0, n_tests = 0;
   dcs_ctrl u_dcs_ctrl (.*);
   dcs_mem_model u_dcs_mem_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_req(o_dma_req), .i_dma(o_dma), .i_err_en(mem_err),
      .o_ack(i_dma_ack), .o_err(i_dma_err), .o_rdata(i_dma_rdata),
      .o_rd_cnt(rd_cnt), .o_wr_cnt(wr_cnt));
   always #50 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      if (o_irq === 1'b1) irq_cnt <= irq_cnt + 16'h1;
      if (o_pos_valid === 1'b1) pos_cnt <= pos_cnt + 16'h1;
   end
   //////////////////////////////////////////////////////////////////////////
   task automatic tick;
      @(posedge i_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic ld(input logic [15:0] bar, disk_address_reg, wc);
      i_bar_wr = 1'b1;
      i_bar_wdata = bar;
      tick;
      i_bar_wr = 1'b0;
      i_bae_wr = 1'b1;
      tick;
      i_bae_wr = 1'b0;
      i_dar_wr = 1'b1;
      i_dar_wdata = disk_address_reg;
      tick;
      i_dar_wr = 1'b0;
      i_wc_wr = 1'b1;
      i_wc_wdata = wc;
      tick;
      i_wc_wr = 1'b0;
   endtask
   task automatic cmd(input logic [2:0] f);
      i_func = f;
      i_go = 1'b1;
      tick;
      i_go = 1'b0;
      tick;
   endtask
   task automatic wait_rdy;
      for (int n = 0; n < 20000 && o_ready !== 1'b1; n++) tick;
      chk({15'h0, o_ready}, 16'h0001);
   endtask
   task automatic st(input logic [15:0] disk_address_reg, wc);
      ld(16'h0400, disk_address_reg, wc);
      cmd(3'h0);
      wait_rdy;
   endtask
   task automatic pop(output logic [15:0] d);
      d = o_multipurpose_reg;
      i_mpr_rd = o_mpr_valid;
      tick;
      i_mpr_rd = 1'b0;
      tick;
   endtask
   // compact form of the same serial loop: msb first, zero start
   function automatic logic [15:0] crc16(input logic [15:0] d);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 15; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
      end
      return c;
   endfunction
   task automatic print_verdict;
      if (err_total == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////
   initial begin
      #4000000;
      err_total++;
      print_verdict;
   end
   initial begin
      logic [15:0] d, irq0;
      {i_rst_n, i_go, i_ie, i_mpr_rd, i_word_moved, i_cmd_done} = '0;
      {i_dar_wr, i_wc_wr, i_bar_wr, i_bae_wr, mem_err} = '0;
      {i_drive_ready, i_drive_err, i_func, i_bae_wdata} = '0;
      {i_dar_wdata, i_wc_wdata, i_bar_wdata} = '0;
      i_err_evt = '0;
      repeat (12) @(posedge i_clk);
      #1 i_rst_n = 1'b1;
      chk({15'h0, o_ready}, 16'h0001);
      i_ie = 1'b1;
      st(16'h12fd, 16'h9fc1);
      chk(o_disk_address_reg, 16'h1203);
      chk(o_status & 16'h3c00, 16'h0000);
      chk(rd_cnt, 16'd256);
      chk(wr_cnt, 16'd255);
      // the pulse is counted one edge after ready rises
      tick;
      chk(irq_cnt, 16'd1);
      chk(pos_cnt, 16'd0);
      for (int n = 0; n < 256; n++) begin
         d = 16'h5a00 ^ 16'(n < 255 ? 16'h0200 + n : 16'h0300 + n);
         chk(u_dcs_mem_model.mem[16'h0300 + n], d);
      end
      pop(d);
      chk(d, crc16(16'h1200));
      pop(d);
      chk(d, crc16(crc16(16'h1201)));
      st(16'h1200, 16'hfe02);
      chk(o_status & 16'h3c00, 16'h1400);
      chk(rd_cnt, 16'd256);
      for (int k = 0; k < 9; k++) begin
         ld(16'h0400, 16'h0000, 16'hff00);
         cmd(3'h6);
         i_err_evt = dcs_err_evt_t'(9'h100 >> k);
         tick;
         i_err_evt = '0;
         wait_rdy;
         chk(16'(o_status[13:10]), 16'(exp_tbl[k]));
      end
      ld(16'h0400, 16'h0000, 16'hfffe);
      cmd(3'h6);
      i_word_moved = 1'b1;
      repeat (2) tick;
      i_word_moved = 1'b0;
      repeat (4) tick;
      chk({15'h0, o_ready}, 16'h0001);
      chk(o_word_count, 16'h0000);
      cmd(3'h6);
      i_cmd_done = 1'b1;
      tick;
      i_cmd_done = 1'b0;
      chk({15'h0, o_ready}, 16'h0001);
      // back-to-back seeks to the same address, heads still moving
      ld(16'h0400, 16'h0081, 16'h0000);
      irq0 = irq_cnt;
      i_func = 3'h3;
      i_go = 1'b1;
      repeat (2) tick;
      i_go = 1'b0;
      repeat (3) tick;
      chk(pos_cnt, 16'd2);
      chk(o_pos_word, 16'h0081);
      chk(irq_cnt - irq0, 16'd2);
      i_drive_ready = 1'b1;
      repeat (5) tick;
      chk(o_status & 16'h00cf, 16'h00c7);
      chk(irq_cnt - irq0, 16'd2);
      i_drive_err = 1'b1;
      repeat (5) tick;
      chk(o_status & 16'hc000, 16'hc000);
      i_drive_err = 1'b0;
      mem_err = 1'b1;
      st(16'h1200, 16'h9fc1);
      chk(o_status & 16'h2000, 16'h2000);
      print_verdict;
   end
endmodule
